/* hdl/seq_pkg.sv */
// seq_pkg: constants, register map and states of the interrupt sequencer
// assumes one 100 MHz core clock and AHB-Lite register access
//
// How it works
// - the core clock drives the sequencer directly, with no divider
// - stack pointer is read, adjusted and written back in one cycle
// - a source is taken only if its enable and global enable are set
// - lock bits may suppress interrupts depending on program counter
// - vectors sit at low addresses; lower vector wins; reset first
// - vector_table_select moves interrupt vectors to boot section start
// - boot_reset_fuse moves the reset vector to boot section start
// - accepting an interrupt clears the global enable bit
// - software setting global enable inside a handler allows nesting
// - vectoring to a flag source clears that source's pending flag
// - writing one to a flag bit clears it; zero leaves it
// - a flag set while disabled stays until serviced or cleared
// - level sources request only while their condition is present
// - after return, one instruction runs before another interrupt
// - status flags are never saved or restored by hardware
// - clear-enable blocks at once, even a same-cycle request
// - after set-enable, the next instruction runs before servicing
// - entry takes four cycles pushing the pc, then the vector runs
// - a multi-cycle instruction finishes before an interrupt is taken
// - waking from sleep adds four response cycles
// - return takes four cycles: pop pc, sp plus two, enable set
// - pushing a return address lowers the stack pointer by two
package seq_pkg;
  localparam int NUM_SRC = 8;
  localparam int IDX_W = 3;
  // sources 6 and 7 are level type, the rest are flag type
  localparam logic [7:0] LEVEL_SRC_MASK = 8'hC0;
  localparam logic [15:0] BOOT_START = 16'hF000;
  localparam logic [15:0] VEC_STRIDE = 16'h0002;
  localparam logic [15:0] RESET_VEC_LOW = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] RET_ADDR_BYTES = 16'h0002;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam int ENTRY_CYCLES = 4;
  localparam int RETURN_CYCLES = 4;
  localparam int WAKE_CYCLES = 4;
  localparam int BOOT_CYCLES = 4;
  // byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAG = 8'h04;
  localparam logic [7:0] OFS_EN = 8'h08;
  localparam logic [7:0] OFS_SP = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_VECTOR = 8'h14;
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_VSEL_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_ENTRY = 3'b011,
    ST_RETURN = 3'b010,
    ST_BOOT = 3'b100
  } seq_state_e;
endpackage

/* hdl/arb_if.sv */
// arb_if: request and grant lines between sequencer and arbiter
// assumes the sequencer samples the grant at instruction boundaries and, while asleep, on any cycle to wake
`timescale 1ns/100ps
interface arb_if;
  logic [seq_pkg::NUM_SRC-1:0] req;
  logic grant_valid;
  logic [seq_pkg::IDX_W-1:0] grant_idx;
  modport arbiter(input req, output grant_valid, output grant_idx);
  modport client(output req, input grant_valid, input grant_idx);
endinterface

/* hdl/prio_arbiter.sv */
// prio_arbiter: fixed priority pick of the lowest requesting index
// assumes requests are already gated by their own enables
`timescale 1ns/100ps
module prio_arbiter (
  arb_if.arbiter arb
);
  import seq_pkg::*;

  // =====================================================================
  // lowest index wins
  // scan from the top so the last hit is the lowest index
  always_comb begin
    arb.grant_valid = 1'b0;
    arb.grant_idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (arb.req[i]) begin
        arb.grant_valid = 1'b1;
        arb.grant_idx = IDX_W'(i);
      end
    end
  end
endmodule

/* hdl/irq_sequencer.sv */
// irq_sequencer: interrupt entry, return and reset vectoring for the core
// assumes core control pulses on clk_i and a stack memory with one cycle
// read latency; fuse and lock pins are asynchronous
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module irq_sequencer (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [seq_pkg::NUM_SRC-1:0] src_event_i,
  input wire logic [seq_pkg::NUM_SRC-1:0] src_level_i,
  input wire logic boot_reset_fuse_i,
  input wire logic app_boot_lock_bit_i,
  input wire logic boot_section_lock_bit_i,
  input wire logic instr_done_i,
  input wire logic sei_i,
  input wire logic cli_i,
  input wire logic return_from_handler_i,
  input wire logic sleep_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] pop_data_i,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic jump_o,
  output logic [15:0] jump_addr_o,
  output logic cpu_hold_o,
  output logic gie_o
);
  import seq_pkg::*;

  seq_state_e state_reg;
  seq_state_e state_next;
  logic [1:0] cnt_reg;
  logic gie_reg;
  logic vsel_reg;
  logic hold_one_reg;
  logic sleep_reg;
  logic fuse_reg;
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [NUM_SRC-1:0] flag_reg;
  logic [NUM_SRC-1:0] flag_next;
  logic [NUM_SRC-1:0] en_reg;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] clr_vec;
  logic [15:0] sp_reg;
  logic [15:0] pc_save_reg;
  logic [15:0] vec_reg;
  logic [15:0] vec_calc;
  logic [7:0] pc_hi_reg;
  logic [IDX_W-1:0] idx_reg;
  logic mem_we_reg;
  logic mem_re_reg;
  logic [15:0] mem_addr_reg;
  logic [7:0] mem_wdata_reg;
  logic jump_reg;
  logic [15:0] jump_addr_reg;
  logic cpu_hold_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] rdata;
  logic bus_go;
  logic gie_eff;
  logic lock_block;
  logic can_take;
  logic take;
  logic wake;
  logic take_any;
  logic ret_go;
  logic boot_end;
  logic entry_end;
  logic ret_end;
  logic wake_end;
  logic flag_wr;

  // =====================================================================
  // pin synchronisers
  // fuse and lock pins are not on clk_i, two stages before any use
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {boot_section_lock_bit_i, app_boot_lock_bit_i,
                     boot_reset_fuse_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // =====================================================================
  // arbitration
  arb_if arb_bus ();

  prio_arbiter u_arb (
    .arb(arb_bus.arbiter)
  );

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    if (LEVEL_SRC_MASK[i]) begin : g_level
      // no memory: a vanished condition never requests
      assign pend[i] = src_level_i[i];
      assign flag_next[i] = 1'b0;
    end else begin : g_flag
      assign pend[i] = flag_reg[i];
      // new event beats a clear in the same cycle
      assign flag_next[i] = src_event_i[i] | (flag_reg[i] & ~clr_vec[i]);
    end
  end

  assign arb_bus.req = pend & en_reg;
  // write-one-to-clear from the bus
  assign clr_vec = (take_any ? (NUM_SRC'(1) << arb_bus.grant_idx) : '0)
                 | (flag_wr ? hwdata_i[NUM_SRC-1:0] : '0);

  // =====================================================================
  // take decision
  // a cli in the same cycle already masks the request
  assign gie_eff = gie_reg & ~cli_i;
  // lock bits guard the section that does not hold the vectors
  assign lock_block = (pin_s2_reg[1] & vsel_reg & (pc_i < BOOT_START))
                    | (pin_s2_reg[2] & ~vsel_reg & (pc_i >= BOOT_START));
  // own enable and global enable both needed
  assign can_take = gie_eff & ~hold_one_reg & ~lock_block
                  & arb_bus.grant_valid;
  assign ret_go = (state_reg == ST_IDLE) & return_from_handler_i;
  // only at a boundary, so multi-cycle instructions finish
  assign take = (state_reg == ST_IDLE) & instr_done_i & ~return_from_handler_i
              & ~sleep_reg & can_take;
  assign wake = (state_reg == ST_IDLE) & sleep_reg & can_take;
  assign take_any = take | wake;
  assign boot_end = (state_reg == ST_BOOT)
                  & (cnt_reg == 2'(BOOT_CYCLES - 1));
  assign entry_end = (state_reg == ST_ENTRY)
                   & (cnt_reg == 2'(ENTRY_CYCLES - 1));
  assign ret_end = (state_reg == ST_RETURN)
                 & (cnt_reg == 2'(RETURN_CYCLES - 1));
  assign wake_end = (state_reg == ST_WAKE)
                  & (cnt_reg == 2'(WAKE_CYCLES - 1));
  // vector index 0 is reset, sources follow; base moves
  assign vec_calc = (vsel_reg ? BOOT_START : RESET_VEC_LOW)
                  + 16'(({13'h0, arb_bus.grant_idx} + 16'h0001)
                  * VEC_STRIDE);

  // =====================================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_BOOT: begin
        if (boot_end) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (ret_go) begin
          state_next = ST_RETURN;
        end else if (take) begin
          state_next = ST_ENTRY;
        end else if (wake) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // extra cycles on top of the wake-up time
        if (wake_end) begin
          state_next = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        if (entry_end) begin
          state_next = ST_IDLE;
        end
      end
      ST_RETURN: begin
        if (ret_end) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // clk_i is the core clock itself, no division anywhere
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_BOOT;
      cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next == state_reg) ? 2'(cnt_reg + 2'h1) : 2'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idx_reg <= '0;
      vec_reg <= RESET_VEC_LOW;
      pc_save_reg <= 16'h0000;
    end else if (take_any) begin
      idx_reg <= arb_bus.grant_idx;
      vec_reg <= vec_calc;
      pc_save_reg <= pc_i;
    end else if (boot_end) begin
      vec_reg <= pin_s2_reg[0] ? BOOT_START : RESET_VEC_LOW;
    end
  end

  // strap caught once, at the end of the boot wait
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fuse_reg <= 1'b0;
    end else if (boot_end) begin
      fuse_reg <= pin_s2_reg[0];
    end
  end

  // only the enable bit moves; other status flags are software's job,
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gie_reg <= 1'b0;
    end else if (take_any) begin
      gie_reg <= 1'b0;
    end else if (cli_i) begin
      gie_reg <= 1'b0;
    end else if (ret_end) begin
      gie_reg <= 1'b1;
    end else if (sei_i) begin
      gie_reg <= 1'b1;
    end else if (wr_pend_reg && addr_reg == OFS_CTRL) begin
      gie_reg <= hwdata_i[CTRL_GIE_BIT];
    end
  end

  // one instruction must pass after sei or return
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_one_reg <= 1'b0;
    end else if (sei_i || ret_end) begin
      hold_one_reg <= 1'b1;
    end else if (instr_done_i) begin
      hold_one_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_reg <= 1'b0;
    end else if (wake) begin
      sleep_reg <= 1'b0;
    end else if (sleep_i) begin
      sleep_reg <= 1'b1;
    end
  end

  // read, adjust and write back in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_reg <= SP_RESET;
    end else if (entry_end) begin
      sp_reg <= 16'(sp_reg - RET_ADDR_BYTES);
    end else if (ret_end) begin
      sp_reg <= 16'(sp_reg + RET_ADDR_BYTES);
    end else if (wr_pend_reg && addr_reg == OFS_SP) begin
      sp_reg <= hwdata_i[15:0];
    end
  end

  // =====================================================================
  // stack traffic
  // low byte at sp, high byte below it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_we_reg <= 1'b0;
      mem_re_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
    end else begin
      mem_we_reg <= (state_reg == ST_ENTRY) && !cnt_reg[1];
      mem_re_reg <= (state_reg == ST_RETURN) && !cnt_reg[1];
      mem_wdata_reg <= cnt_reg[0] ? pc_save_reg[15:8] : pc_save_reg[7:0];
      if (state_reg == ST_RETURN) begin
        mem_addr_reg <= 16'(sp_reg + {14'h0, cnt_reg} + 16'h0001);
      end else begin
        mem_addr_reg <= 16'(sp_reg - {14'h0, cnt_reg});
      end
    end
  end

  // memory answers one cycle after the read strobe is seen
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_hi_reg <= 8'h00;
    end else if (state_reg == ST_RETURN && cnt_reg == 2'h2) begin
      pc_hi_reg <= pop_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jump_reg <= 1'b0;
      jump_addr_reg <= 16'h0000;
      cpu_hold_reg <= 1'b1;
    end else begin
      jump_reg <= boot_end | entry_end | ret_end;
      cpu_hold_reg <= (state_next != ST_IDLE);
      if (ret_end) begin
        jump_addr_reg <= {pc_hi_reg, pop_data_i};
      end else if (boot_end) begin
        jump_addr_reg <= pin_s2_reg[0] ? BOOT_START : RESET_VEC_LOW;
      end else if (entry_end) begin
        jump_addr_reg <= vec_reg;
      end
    end
  end

  // =====================================================================
  // ahb-lite slave
  // reads take one wait state so a write just before is always seen
  assign bus_go = hsel_i & htrans_i[1] & hready_i;
  assign flag_wr = wr_pend_reg && (addr_reg == OFS_FLAG);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
    end else begin
      wr_pend_reg <= bus_go & hwrite_i & (hsize_i == HSIZE_WORD);
      rd_pend_reg <= bus_go & ~hwrite_i;
      hreadyout_reg <= ~(bus_go & ~hwrite_i);
      if (bus_go) begin
        addr_reg <= haddr_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vsel_reg <= 1'b0;
      en_reg <= EN_RESET;
    end else if (wr_pend_reg) begin
      if (addr_reg == OFS_CTRL) begin
        vsel_reg <= hwdata_i[CTRL_VSEL_BIT];
      end
      if (addr_reg == OFS_EN) begin
        en_reg <= hwdata_i[NUM_SRC-1:0];
      end
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (addr_reg)
      OFS_CTRL: rdata = {30'h0, vsel_reg, gie_reg};
      OFS_FLAG: rdata = {24'h0, flag_reg | (pend & LEVEL_SRC_MASK)};
      OFS_EN: rdata = {24'h0, en_reg};
      OFS_SP: rdata = {16'h0, sp_reg};
      OFS_STATUS: rdata = {22'h0, idx_reg, fuse_reg, sleep_reg,
                           hold_one_reg, 1'b0, state_reg};
      OFS_VECTOR: rdata = {16'h0, vec_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rdata;
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = 1'b0;
  assign mem_we_o = mem_we_reg;
  assign mem_re_o = mem_re_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign jump_o = jump_reg;
  assign jump_addr_o = jump_addr_reg;
  assign cpu_hold_o = cpu_hold_reg;
  assign gie_o = gie_reg;

  // =====================================================================
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_take_clears_gie: assert property (take |=> !gie_reg)
    else $error("global enable still set after take");
  a_cli_blocks_take: assert property (
    (cli_i && state_reg == ST_IDLE) |=> state_reg != ST_ENTRY)
    else $error("interrupt entered after clear-enable");
  a_sei_next_instr: assert property (sei_i |=> !take)
    else $error("interrupt taken right after set-enable");
  a_entry_four_cycles: assert property (
    take |=> ##1 (mem_we_o && mem_addr_o == $past(sp_reg, 2))
    ##3 (jump_o && jump_addr_o == $past(vec_calc, 5)))
    else $error("entry push or vector timing wrong");
  a_entry_sp_minus: assert property (
    take |-> ##5 (sp_reg == 16'($past(sp_reg, 5) - 16'h0002)))
    else $error("stack pointer not lowered by two");
  a_return_sequence: assert property (
    (ret_go && !wr_pend_reg) |-> ##5 (gie_reg && jump_o
    && sp_reg == 16'($past(sp_reg, 5) + 16'h0002)))
    else $error("return sequence wrong");
  a_return_one_instr: assert property (
    ret_go |-> ##5 hold_one_reg)
    else $error("no instruction allowed after return");
  a_wake_extra: assert property (wake |-> ##9 jump_o)
    else $error("wake entry timing wrong");
  a_flag_latched: assert property (
    (clr_vec == '0) |=> ((flag_reg & $past(flag_reg)) == $past(flag_reg)))
    else $error("pending flag lost without clear");
  a_flag_w1c: assert property (
    (flag_wr && !take_any && src_event_i == '0)
    |=> flag_reg == $past(flag_reg & ~hwdata_i[NUM_SRC-1:0]))
    else $error("write-one-to-clear wrong");
  a_lowest_wins: assert property (
    arb_bus.grant_valid |-> (arb_bus.req[arb_bus.grant_idx]
    && (arb_bus.req & 8'((8'h01 << arb_bus.grant_idx) - 8'h01)) == 8'h00))
    else $error("grant not lowest request");
endmodule

/* dv/stack_model.sv */
// stack_model: byte-wide stack memory facing the sequencer
// assumes read data is wanted one cycle after the read strobe
`timescale 1ns/100ps
module stack_model (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  initial rdata_o = 8'h00;
  // ==========================================================
  // storage
  // idle cycles flip the data so a stale byte never looks valid
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
  end
endmodule

/* dv/cpu_interrupt_sequencer_bench.sv */
// cpu_interrupt_sequencer_bench: bus and core-side tests of irq_sequencer
// assumes the stack model answers reads after one cycle
`timescale 1ns/100ps
module cpu_interrupt_sequencer_bench;
  import seq_pkg::*;
  logic clk_i, resetn_i, hsel_i, hwrite_i, hready_i, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic hreadyout_o, boot_reset_fuse_i, app_boot_lock_bit_i;
  logic boot_section_lock_bit_i, instr_done_i, sei_i, cli_i, return_from_handler_i;
  logic sleep_i, mem_we_o, mem_re_o, jump_o, cpu_hold_o, gie_o;
  logic [7:0] src_event_i, src_level_i, pop_data_i, mem_wdata_o;
  logic [15:0] pc_i, mem_addr_o, jump_addr_o;
  int err_total, n_tests, n;
  assign hready_i = hreadyout_o;
  irq_sequencer u_dut (
    .clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .src_event_i, .src_level_i, .boot_reset_fuse_i,
    .app_boot_lock_bit_i, .boot_section_lock_bit_i, .instr_done_i,
    .sei_i, .cli_i, .return_from_handler_i, .sleep_i, .pc_i, .pop_data_i, .mem_we_o,
    .mem_re_o, .mem_addr_o, .mem_wdata_o, .jump_o, .jump_addr_o,
    .cpu_hold_o, .gie_o
  );
  stack_model u_stack (
    .clk_i, .we_i(mem_we_o), .re_i(mem_re_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rdata_o(pop_data_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic ready_wait();
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 40);
    if (hreadyout_o !== 1'b1) begin
      err_total++;
      complete_run();
    end
  endtask
  // bounded wait for the boot jump after a reset release
  task automatic boot_wait();
    n = 0;
    while (jump_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (jump_o !== 1'b1) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h000000, a};
    ready_wait();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    ready_wait();
    rd = hrdata_o;
  endtask
  task automatic ev(input logic [7:0] m);
    @(posedge clk_i);
    src_event_i <= m;
    @(posedge clk_i);
    src_event_i <= 8'h00;
  endtask
  // one instruction boundary; n counts edges until jump, 12 if none
  task automatic step(input logic c, input logic r, input logic s);
    @(posedge clk_i);
    instr_done_i <= 1'b1;
    cli_i <= c;
    return_from_handler_i <= r;
    sei_i <= s;
    @(posedge clk_i);
    {instr_done_i, cli_i, return_from_handler_i, sei_i} <= 4'h0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (jump_o !== 1'b1 && n < 12);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // ==========================================================
  // sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    {hsel_i, hwrite_i, instr_done_i, sei_i, cli_i, return_from_handler_i} = 6'h00;
    {boot_reset_fuse_i, app_boot_lock_bit_i} = 2'h0;
    {boot_section_lock_bit_i, sleep_i} = 2'h0;
    haddr_i = 32'h00000000;
    hwdata_i = 32'h00000000;
    htrans_i = 2'h0;
    hsize_i = HSIZE_WORD;
    src_event_i = 8'h00;
    src_level_i = 8'h00;
    pc_i = 16'h1234;
    resetn_i = 1'b0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk(32'(cpu_hold_o), 32'h1);
    boot_wait();
    chk(n, BOOT_CYCLES);
    chk(32'(jump_addr_o), 32'(RESET_VEC_LOW));
    chk(32'(cpu_hold_o), 32'h0);
    chk(32'(gie_o), 32'h0);
    chk(32'(hresp_o), 32'h0);
    done("reset");
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, OFS_SP, 32'h00000100);
    bus(1'b0, OFS_SP, 32'h0);
    chk(rd, 32'h00000100);
    src_level_i <= 8'h40;
    ev(8'h02);
    bus(1'b0, OFS_FLAG, 32'h0);
    chk(rd, 32'h00000042);
    src_level_i <= 8'h00;
    bus(1'b1, OFS_FLAG, 32'h0);
    bus(1'b0, OFS_FLAG, 32'h0);
    chk(rd, 32'h00000002);
    bus(1'b1, OFS_FLAG, 32'h2);
    bus(1'b0, OFS_FLAG, 32'h0);
    chk(rd, 32'h0);
    done("flags");
    bus(1'b1, OFS_EN, 32'h07);
    bus(1'b1, OFS_CTRL, 32'h1);
    ev(8'h03);
    step(1'b0, 1'b0, 1'b0);
    chk(n, ENTRY_CYCLES);
    chk(32'(jump_addr_o), 32'(VEC_STRIDE));
    chk(32'(gie_o), 32'h0);
    chk(32'(cpu_hold_o), 32'h0);
    chk(32'(u_stack.mem[16'h0100]), 32'h34);
    chk(32'(u_stack.mem[16'h00FF]), 32'h12);
    bus(1'b0, OFS_SP, 32'h0);
    chk(rd, 32'h0100 - 32'(RET_ADDR_BYTES));
    bus(1'b0, OFS_FLAG, 32'h0);
    chk(rd, 32'h00000002);
    done("entry");
    step(1'b0, 1'b1, 1'b0);
    chk(n, RETURN_CYCLES);
    chk(32'(jump_addr_o), 32'h1234);
    chk(32'(gie_o), 32'h1);
    bus(1'b0, OFS_SP, 32'h0);
    chk(rd, 32'h00000100);
    step(1'b0, 1'b0, 1'b0);
    chk(n, 12);
    step(1'b1, 1'b0, 1'b0);
    chk(n, 12);
    chk(32'(gie_o), 32'h0);
    step(1'b0, 1'b0, 1'b1);
    step(1'b0, 1'b0, 1'b0);
    chk(n, 12);
    step(1'b0, 1'b0, 1'b0);
    chk(32'(jump_addr_o), 32'(2 * VEC_STRIDE));
    done("return");
    pc_i <= 16'h0456;
    bus(1'b1, OFS_CTRL, 32'h3);
    ev(8'h04);
    step(1'b0, 1'b0, 1'b0);
    chk(n, ENTRY_CYCLES);
    chk(32'(jump_addr_o), 32'(BOOT_START + 3 * VEC_STRIDE));
    chk(32'(u_stack.mem[16'h00FE]), 32'h56);
    bus(1'b0, OFS_SP, 32'h0);
    chk(rd, 32'h000000FC);
    done("nesting");
    // lock pin passes two sync stages well before the boundary
    app_boot_lock_bit_i <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h3);
    ev(8'h01);
    step(1'b0, 1'b0, 1'b0);
    chk(n, 12);
    done("lock");
    app_boot_lock_bit_i <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h1);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    sleep_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (jump_o !== 1'b1 && n < 20);
    // one extra edge: the sleep pulse is registered before the wake
    chk(n, WAKE_CYCLES + ENTRY_CYCLES + 1);
    chk(32'(jump_addr_o), 32'(VEC_STRIDE));
    chk(32'(u_stack.mem[16'h00FC]), 32'h56);
    done("sleep");
    @(posedge clk_i);
    boot_reset_fuse_i <= 1'b1;
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    boot_wait();
    chk(32'(jump_addr_o), 32'(BOOT_START));
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h00000040);
    bus(1'b0, OFS_SP, 32'h0);
    chk(rd, 32'(SP_RESET));
    done("fuse");
    complete_run();
  end
endmodule
